// [cpu_register_set.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_params.svh"

module cpu_register_set (
    input wire logic core_clk,
    input wire logic resetn,
    input wire cpu_register_set_pkg::reg_op_t op,
    input wire logic [7:0] operand,
    input wire logic [7:0] logic_result,
    input wire logic index_write,
    input wire logic [7:0] index_value,
    input wire logic shift_carry,
    input wire logic [15:0] pc_target,
    input wire logic [`IRQ_LINES-1:0] irq_request,
    input wire logic trap_request,
    input wire logic irq_taken,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] accumulator,
    output logic [7:0] index_first,
    output logic [7:0] index_second,
    output logic use_second_index,
    output logic [7:0] prog_count_low,
    output logic [7:0] prog_count_high,
    output logic [15:0] program_counter,
    output logic [7:0] condition_flags,
    output logic [15:0] stack_pointer,
    output logic [`IRQ_LINES-1:0] irq_pending,
    output logic irq_service,
    output logic seq_busy,
    output logic mem_we,
    output logic mem_re,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata
);

    cpu_register_set_pkg::seq_state_t state;
    cpu_register_set_pkg::seq_state_t next_state;
    logic [2:0] step;
    logic [2:0] next_step;
    logic [2:0] last_step;
    logic [2:0] next_last_step;
    logic is_context;
    logic next_is_context;
    logic [7:0] next_accumulator;
    logic [7:0] next_index_first;
    logic [7:0] next_index_second;
    logic next_use_second;
    logic [15:0] next_pc;
    logic [7:0] next_flags;
    logic [`IRQ_LINES-1:0] next_pending;
    logic [15:0] pop_address;
    logic push_step;
    logic pop_step;
    logic [8:0] sum;
    logic [4:0] half_sum;
    logic [7:0] result;
    logic carry_in;

    // Push order for interrupt context; pops walk it backwards
    function automatic logic [7:0] context_byte(input logic [2:0] idx,
                                                input logic [15:0] pc,
                                                input logic [7:0] xr,
                                                input logic [7:0] ar,
                                                input logic [7:0] fl);
        case (idx)
            3'd0: context_byte = pc[7:0];
            3'd1: context_byte = pc[15:8];
            3'd2: context_byte = xr;
            3'd3: context_byte = ar;
            default: context_byte = fl;
        endcase
    endfunction : context_byte

    function automatic logic [7:0] set_result_flags(input logic [7:0] fl,
                                                    input logic [7:0] res);
        logic [7:0] f;
        f = fl;
        f[`FLAG_NEG_BIT] = res[7];
        f[`FLAG_ZERO_BIT] = (res == 8'h00);
        set_result_flags = f;
    endfunction : set_result_flags

    assign program_counter = {prog_count_high, prog_count_low};
    assign seq_busy = (state != cpu_register_set_pkg::SEQ_IDLE);
    // Trap ignores the mask; maskable lines only while mask is clear
    assign irq_service = trap_request
        | ((|irq_pending) & ~condition_flags[`FLAG_MASK_BIT]);

    stack_pointer_unit sp_unit (
        .core_clk(core_clk),
        .resetn(resetn),
        .stack_reset(op == cpu_register_set_pkg::OP_STACK_RESET && !seq_busy),
        .load_low(op == cpu_register_set_pkg::OP_LOAD_SP_LOW && !seq_busy),
        .load_value(operand),
        .push_step(push_step),
        .pop_step(pop_step),
        .stack_pointer(stack_pointer),
        .pop_address(pop_address)
    );

    always_comb begin
        carry_in = (op == cpu_register_set_pkg::OP_ADC) & condition_flags[`FLAG_CARRY_BIT];
        sum = {1'b0, accumulator} + {1'b0, operand} + {8'h00, carry_in};
        half_sum = {1'b0, accumulator[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
        if (op == cpu_register_set_pkg::OP_SUB) begin
            sum = {1'b0, accumulator} - {1'b0, operand};
        end
        result = sum[7:0];
    end

    always_comb begin
        next_state = state;
        next_step = step;
        next_last_step = last_step;
        next_is_context = is_context;
        next_accumulator = accumulator;
        next_index_first = index_first;
        next_index_second = index_second;
        next_use_second = use_second_index;
        next_pc = program_counter;
        next_flags = condition_flags;
        // Set wins: a request in the servicing cycle stays pending
        next_pending = (irq_pending & ~({`IRQ_LINES{irq_taken}} & irq_pending))
            | irq_request;
        push_step = 1'b0;
        pop_step = 1'b0;
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_addr = stack_pointer;
        mem_wdata = 8'h00;
        unique case (state)
            cpu_register_set_pkg::SEQ_IDLE: begin
                if (irq_taken) begin
                    next_state = cpu_register_set_pkg::SEQ_PUSH;
                    next_step = 3'd0;
                    next_last_step = 3'(`CTX_BYTES - 1);
                    next_is_context = 1'b1;
                end else begin
                    unique case (op)
                        cpu_register_set_pkg::OP_ADD,
                        cpu_register_set_pkg::OP_ADC: begin
                            next_accumulator = result;
                            next_flags[`FLAG_HALF_BIT] = half_sum[4];
                            next_flags[`FLAG_CARRY_BIT] = sum[8];
                            next_flags = set_result_flags(next_flags, result);
                        end
                        cpu_register_set_pkg::OP_SUB: begin
                            next_accumulator = result;
                            next_flags[`FLAG_CARRY_BIT] = sum[8];
                            next_flags = set_result_flags(next_flags, result);
                        end
                        cpu_register_set_pkg::OP_LOGIC,
                        cpu_register_set_pkg::OP_LOAD_A: begin
                            next_accumulator = logic_result;
                            next_flags = set_result_flags(next_flags, logic_result);
                        end
                        cpu_register_set_pkg::OP_LOAD_X: begin
                            next_flags = set_result_flags(next_flags, index_value);
                        end
                        cpu_register_set_pkg::OP_SHIFT: begin
                            next_accumulator = logic_result;
                            next_flags[`FLAG_CARRY_BIT] = shift_carry;
                            next_flags = set_result_flags(next_flags, logic_result);
                        end
                        cpu_register_set_pkg::OP_BIT_TEST:
                            next_flags[`FLAG_CARRY_BIT] = shift_carry;
                        cpu_register_set_pkg::OP_CARRY_SET:
                            next_flags[`FLAG_CARRY_BIT] = 1'b1;
                        cpu_register_set_pkg::OP_CARRY_CLEAR:
                            next_flags[`FLAG_CARRY_BIT] = 1'b0;
                        cpu_register_set_pkg::OP_MASK_SET:
                            next_flags[`FLAG_MASK_BIT] = 1'b1;
                        cpu_register_set_pkg::OP_MASK_CLEAR:
                            next_flags[`FLAG_MASK_BIT] = 1'b0;
                        cpu_register_set_pkg::OP_PUSH_A: begin
                            mem_we = 1'b1;
                            mem_wdata = accumulator;
                            push_step = 1'b1;
                        end
                        cpu_register_set_pkg::OP_PUSH_FLAGS: begin
                            mem_we = 1'b1;
                            mem_wdata = condition_flags;
                            push_step = 1'b1;
                        end
                        cpu_register_set_pkg::OP_POP_A: begin
                            mem_re = 1'b1;
                            mem_addr = pop_address;
                            next_accumulator = mem_rdata;
                            pop_step = 1'b1;
                        end
                        cpu_register_set_pkg::OP_POP_FLAGS: begin
                            mem_re = 1'b1;
                            mem_addr = pop_address;
                            next_flags = mem_rdata;
                            pop_step = 1'b1;
                        end
                        cpu_register_set_pkg::OP_CALL: begin
                            next_state = cpu_register_set_pkg::SEQ_PUSH;
                            next_step = 3'd0;
                            next_last_step = 3'(`CALL_BYTES - 1);
                            next_is_context = 1'b0;
                        end
                        cpu_register_set_pkg::OP_RETURN: begin
                            next_state = cpu_register_set_pkg::SEQ_POP;
                            next_step = 3'(`CALL_BYTES - 1);
                            next_is_context = 1'b0;
                        end
                        cpu_register_set_pkg::OP_INTERRUPT_RETURN: begin
                            next_state = cpu_register_set_pkg::SEQ_POP;
                            next_step = 3'(`CTX_BYTES - 1);
                            next_is_context = 1'b1;
                        end
                        cpu_register_set_pkg::OP_SECOND_INDEX_PREFIX:
                            next_use_second = 1'b1;
                        cpu_register_set_pkg::OP_LOAD_PC:
                            next_pc = pc_target;
                        cpu_register_set_pkg::OP_INC_PC:
                            next_pc = program_counter + 16'h0001;
                        default: ;
                    endcase
                    // Prefix lasts for exactly one following instruction
                    if (op != cpu_register_set_pkg::OP_SECOND_INDEX_PREFIX
                        && op != cpu_register_set_pkg::OP_NONE) begin
                        next_use_second = 1'b0;
                    end
                    if (index_write) begin
                        if (use_second_index) begin
                            next_index_second = index_value;
                        end else begin
                            next_index_first = index_value;
                        end
                    end
                end
            end
            cpu_register_set_pkg::SEQ_PUSH: begin
                mem_we = 1'b1;
                mem_wdata = context_byte(step, program_counter, index_first,
                                         accumulator, condition_flags);
                push_step = 1'b1;
                next_step = step + 3'd1;
                if (step == last_step) begin
                    next_state = cpu_register_set_pkg::SEQ_IDLE;
                    if (is_context) begin
                        next_flags[`FLAG_MASK_BIT] = 1'b1;
                    end
                    next_pc = pc_target;
                end
            end
            cpu_register_set_pkg::SEQ_POP: begin
                mem_re = 1'b1;
                mem_addr = pop_address;
                pop_step = 1'b1;
                next_step = step - 3'd1;
                // Second index is not part of the saved frame
                unique case (step)
                    3'd0: next_pc = {program_counter[15:8], mem_rdata};
                    3'd1: next_pc = {mem_rdata, program_counter[7:0]};
                    3'd2: next_index_first = mem_rdata;
                    3'd3: next_accumulator = mem_rdata;
                    default: next_flags = mem_rdata;
                endcase
                if (step == 3'd0) begin
                    next_state = cpu_register_set_pkg::SEQ_IDLE;
                    if (is_context) begin
                        next_flags[`FLAG_MASK_BIT] = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= cpu_register_set_pkg::SEQ_IDLE;
            step <= 3'd0;
            last_step <= 3'd0;
            is_context <= 1'b0;
            accumulator <= `DATA_RESET;
            index_first <= `DATA_RESET;
            index_second <= `DATA_RESET;
            use_second_index <= 1'b0;
            prog_count_low <= 8'(`PC_RESET);
            prog_count_high <= 8'h00;
            condition_flags <= `FLAGS_RESET;
            irq_pending <= '0;
        end else begin
            state <= next_state;
            step <= next_step;
            last_step <= next_last_step;
            is_context <= next_is_context;
            accumulator <= next_accumulator;
            index_first <= next_index_first;
            index_second <= next_index_second;
            use_second_index <= next_use_second;
            prog_count_low <= next_pc[7:0];
            prog_count_high <= next_pc[15:8];
            condition_flags <= next_flags;
            irq_pending <= next_pending;
        end
    end

endmodule : cpu_register_set
`default_nettype wire

// [cpu_register_set_params.svh]
`ifndef CPU_REGISTER_SET_PARAMS_SVH
`define CPU_REGISTER_SET_PARAMS_SVH

`define FLAG_HALF_BIT 4
`define FLAG_MASK_BIT 3
`define FLAG_NEG_BIT 2
`define FLAG_ZERO_BIT 1
`define FLAG_CARRY_BIT 0
`define FLAGS_RESET 8'hE8
`define SP_RESET 16'h00FF
`define SP_FIXED_HIGH 10'h003
`define SP_LOW_BITS 6
`define DATA_RESET 8'h00
`define PC_RESET 16'h0000
`define IRQ_LINES 8
`define CTX_BYTES 5
`define CALL_BYTES 2

`endif

// [cpu_register_set_pkg.sv]
package cpu_register_set_pkg;

    // Operations driven by the core's decode logic, one per cycle
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ADD,
        OP_ADC,
        OP_SUB,
        OP_LOGIC,
        OP_LOAD_A,
        OP_LOAD_X,
        OP_SHIFT,
        OP_BIT_TEST,
        OP_CARRY_SET,
        OP_CARRY_CLEAR,
        OP_MASK_SET,
        OP_MASK_CLEAR,
        OP_STACK_RESET,
        OP_LOAD_SP_LOW,
        OP_PUSH_A,
        OP_PUSH_FLAGS,
        OP_POP_A,
        OP_POP_FLAGS,
        OP_CALL,
        OP_RETURN,
        OP_INTERRUPT_RETURN,
        OP_SECOND_INDEX_PREFIX,
        OP_LOAD_PC,
        OP_INC_PC
    } reg_op_t;

    typedef enum {
        SEQ_IDLE,
        SEQ_PUSH,
        SEQ_POP
    } seq_state_t;

endpackage : cpu_register_set_pkg

// [stack_pointer_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_params.svh"

module stack_pointer_unit (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic stack_reset,
    input wire logic load_low,
    input wire logic [7:0] load_value,
    input wire logic push_step,
    input wire logic pop_step,
    output logic [15:0] stack_pointer,
    output logic [15:0] pop_address
);

    logic [`SP_LOW_BITS-1:0] low_bits;
    logic [`SP_LOW_BITS-1:0] next_low_bits;

    // Upper ten bits are hard-wired, so overflow simply wraps the low six
    assign stack_pointer = {`SP_FIXED_HIGH, low_bits};
    // Pop pre-increments: the byte read sits one above the free slot
    assign pop_address = {`SP_FIXED_HIGH, low_bits + 6'h01};

    always_comb begin
        next_low_bits = low_bits;
        if (stack_reset) begin
            next_low_bits = 6'(`SP_RESET);
        end else if (load_low) begin
            next_low_bits = load_value[`SP_LOW_BITS-1:0];
        end else if (push_step) begin
            next_low_bits = low_bits - 6'h01;
        end else if (pop_step) begin
            next_low_bits = low_bits + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            low_bits <= 6'h3F;
        end else begin
            low_bits <= next_low_bits;
        end
    end

endmodule : stack_pointer_unit
`default_nettype wire

// [cpu_register_set_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_params.svh"
module cpu_register_set_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire cpu_register_set_pkg::reg_op_t op,
    input wire logic [7:0] operand,
    input wire logic [7:0] logic_result,
    input wire logic [`IRQ_LINES-1:0] irq_request,
    input wire logic irq_taken,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] index_first,
    input wire logic use_second_index,
    input wire logic [7:0] prog_count_low,
    input wire logic [7:0] prog_count_high,
    input wire logic [7:0] condition_flags,
    input wire logic [15:0] stack_pointer,
    input wire logic [`IRQ_LINES-1:0] irq_pending,
    input wire logic irq_service,
    input wire logic seq_busy,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata
);
    logic [8:0] full_sum;
    logic [4:0] half_sum;
    logic go;
    assign full_sum = {1'h0, accumulator} + {1'h0, operand};
    assign half_sum = {1'h0, accumulator[3:0]} + {1'h0, operand[3:0]};
    // Ops are only taken while no push or pop sequence runs
    assign go = !seq_busy;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_sp_fixed;
        stack_pointer[15:6] == 10'h003;
    endproperty
    a_sp_fixed: assert property (p_sp_fixed) else $error("stack upper bits moved");
    property p_stack_reset;
        op == cpu_register_set_pkg::OP_STACK_RESET && go |=> stack_pointer == 16'h00FF;
    endproperty
    a_stack_reset: assert property (p_stack_reset) else $error("stack reset wrong");
    property p_load_sp;
        op == cpu_register_set_pkg::OP_LOAD_SP_LOW && go
            |=> stack_pointer[5:0] == $past(operand[5:0]);
    endproperty
    a_load_sp: assert property (p_load_sp) else $error("stack low load wrong");
    property p_push_step;
        mem_we |-> mem_addr == stack_pointer
            ##1 stack_pointer[5:0] == $past(stack_pointer[5:0]) - 6'h01;
    endproperty
    a_push_step: assert property (p_push_step) else $error("push address or step wrong");
    property p_pop_step;
        mem_re |-> mem_addr == {10'h003, stack_pointer[5:0] + 6'h01}
            ##1 stack_pointer[5:0] == $past(stack_pointer[5:0]) + 6'h01;
    endproperty
    a_pop_step: assert property (p_pop_step) else $error("pop address or step wrong");
    property p_add;
        op == cpu_register_set_pkg::OP_ADD && go |=> accumulator == $past(full_sum[7:0])
            && condition_flags[4] == $past(half_sum[4]) && condition_flags[0] == $past(full_sum[8]);
    endproperty
    a_add: assert property (p_add) else $error("add result or carries wrong");
    property p_load_nz;
        op == cpu_register_set_pkg::OP_LOAD_A && go |=> condition_flags[2] == $past(logic_result[7])
            && condition_flags[1] == ($past(logic_result) == 8'h00);
    endproperty
    a_load_nz: assert property (p_load_nz) else $error("negative or zero flag wrong");
    property p_carry_set;
        op == cpu_register_set_pkg::OP_CARRY_SET && go |=> condition_flags[0];
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry not set");
    property p_prefix;
        op == cpu_register_set_pkg::OP_SECOND_INDEX_PREFIX && go |=> use_second_index;
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix not armed");
    property p_ctx_five;
        irq_taken && go |=> mem_we [*5] ##1 !mem_we;
    endproperty
    a_ctx_five: assert property (p_ctx_five) else $error("context not five bytes");
    property p_ctx_order;
        irq_taken && go |=> mem_wdata == prog_count_low ##1 mem_wdata == prog_count_high
            ##1 mem_wdata == index_first ##1 mem_wdata == accumulator
            ##1 mem_wdata == condition_flags;
    endproperty
    a_ctx_order: assert property (p_ctx_order) else $error("context order wrong");
    property p_mask_entry;
        irq_taken && go |-> ##6 condition_flags[3];
    endproperty
    a_mask_entry: assert property (p_mask_entry) else $error("mask not set on entry");
    property p_latch;
        irq_request != 8'h00 && condition_flags[3]
            |=> (irq_pending & $past(irq_request)) == $past(irq_request);
    endproperty
    a_latch: assert property (p_latch) else $error("masked request lost");
    property p_interrupt_return_instr_mask;
        op == cpu_register_set_pkg::OP_INTERRUPT_RETURN && go |-> ##6 !condition_flags[3];
    endproperty
    a_interrupt_return_instr_mask: assert property (p_interrupt_return_instr_mask) else $error("return left mask set");
endmodule : cpu_register_set_sva
bind cpu_register_set cpu_register_set_sva u_sva (.core_clk, .resetn, .op, .operand,
    .logic_result, .irq_request, .irq_taken, .accumulator, .index_first, .use_second_index,
    .prog_count_low, .prog_count_high, .condition_flags, .stack_pointer, .irq_pending,
    .irq_service, .seq_busy, .mem_we, .mem_re, .mem_addr, .mem_wdata);
`default_nettype wire

// [cpu_register_set_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_params.svh"
module cpu_register_set_tb;
    logic core_clk, resetn, index_write, shift_carry, trap_request, irq_taken;
    cpu_register_set_pkg::reg_op_t op;
    logic [7:0] operand, logic_result, index_value, accumulator, index_first, index_second;
    logic [7:0] prog_count_low, prog_count_high, condition_flags, mem_wdata;
    logic [15:0] pc_target, program_counter, stack_pointer, mem_addr;
    logic [`IRQ_LINES-1:0] irq_request, irq_pending;
    logic use_second_index, irq_service, seq_busy, mem_we, mem_re;
    logic [7:0] stack_mem [0:63];
    wire logic [7:0] mem_rdata;
    int n_mismatch, checks;
    cpu_register_set dut (.core_clk, .resetn, .op, .operand, .logic_result, .index_write,
        .index_value, .shift_carry, .pc_target, .irq_request, .trap_request, .irq_taken,
        .mem_rdata, .accumulator, .index_first, .index_second, .use_second_index,
        .prog_count_low, .prog_count_high, .program_counter, .condition_flags, .stack_pointer,
        .irq_pending, .irq_service, .seq_busy, .mem_we, .mem_re, .mem_addr, .mem_wdata);
    // Stack RAM answers reads in the same cycle, as the core expects
    assign mem_rdata = stack_mem[mem_addr[5:0]];
    always @(posedge core_clk) begin
        if (mem_we) begin
            stack_mem[mem_addr[5:0]] <= mem_wdata;
        end
    end
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // One op per two cycles keeps each driven value to a single assignment per edge
    task automatic issue(input cpu_register_set_pkg::reg_op_t o, input logic [7:0] v);
        @(posedge core_clk);
        op <= o;
        operand <= v;
        logic_result <= v;
        shift_carry <= v[0];
        @(posedge core_clk);
        op <= cpu_register_set_pkg::OP_NONE;
        #1;
    endtask : issue
    task automatic write_index(input logic [7:0] v);
        @(posedge core_clk);
        index_write <= 1'h1;
        index_value <= v;
        @(posedge core_clk);
        index_write <= 1'h0;
        #1;
    endtask : write_index
    task automatic test_reset;
        check("flags", condition_flags, 16'h00E8);
        check("sp", stack_pointer, 16'h00FF);
        check("acc", accumulator, 16'h0000);
        check("pc", program_counter, 16'h0000);
        $display("test reset done");
    endtask : test_reset
    task automatic test_stack;
        issue(cpu_register_set_pkg::OP_LOAD_SP_LOW, 8'h01);
        check("sp load", stack_pointer, 16'h00C1);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h77);
        issue(cpu_register_set_pkg::OP_PUSH_A, 8'h00);
        check("push byte", stack_mem[1], 16'h0077);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h22);
        issue(cpu_register_set_pkg::OP_PUSH_A, 8'h00);
        check("push lowest", stack_mem[0], 16'h0022);
        check("sp wrap down", stack_pointer, 16'h00FF);
        issue(cpu_register_set_pkg::OP_POP_A, 8'h00);
        check("pop wrap", accumulator, 16'h0022);
        check("sp wrap up", stack_pointer, 16'h00C0);
        issue(cpu_register_set_pkg::OP_POP_A, 8'h00);
        check("pop byte", accumulator, 16'h0077);
        issue(cpu_register_set_pkg::OP_STACK_RESET, 8'h00);
        check("sp reset", stack_pointer, 16'h00FF);
        $display("test stack done");
    endtask : test_stack
    task automatic test_alu;
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h80);
        check("neg", condition_flags[2:1], 16'h0002);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h00);
        check("zero", condition_flags[2:1], 16'h0001);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h08);
        issue(cpu_register_set_pkg::OP_ADD, 8'h08);
        check("add sum", accumulator, 16'h0010);
        check("half", condition_flags[4], 16'h0001);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'hFF);
        issue(cpu_register_set_pkg::OP_ADD, 8'h01);
        check("carry zero", condition_flags[1:0], 16'h0003);
        issue(cpu_register_set_pkg::OP_CARRY_CLEAR, 8'h00);
        check("carry clear", condition_flags[0], 16'h0000);
        issue(cpu_register_set_pkg::OP_CARRY_SET, 8'h00);
        check("flags", condition_flags, 16'h00FB);
        issue(cpu_register_set_pkg::OP_ADC, 8'h01);
        check("adc", {accumulator, condition_flags}, 16'h02E8);
        issue(cpu_register_set_pkg::OP_SUB, 8'h04);
        check("sub", {accumulator, condition_flags}, 16'hFEED);
        issue(cpu_register_set_pkg::OP_SHIFT, 8'h80);
        issue(cpu_register_set_pkg::OP_BIT_TEST, 8'h01);
        check("shift", {accumulator, condition_flags}, 16'h80ED);
        $display("test alu done");
    endtask : test_alu
    task automatic test_irq;
        write_index(8'h3C);
        issue(cpu_register_set_pkg::OP_SECOND_INDEX_PREFIX, 8'h00);
        write_index(8'hC3);
        check("second index", {index_second, index_first}, 16'hC33C);
        issue(cpu_register_set_pkg::OP_LOAD_PC, 8'h00);
        check("pc load", {prog_count_high, prog_count_low}, 16'hA55A);
        @(posedge core_clk);
        irq_request <= 8'h04;
        @(posedge core_clk);
        irq_request <= 8'h00;
        #1;
        check("latched", irq_pending[2], 16'h0001);
        check("masked", irq_service, 16'h0000);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h81);
        issue(cpu_register_set_pkg::OP_MASK_CLEAR, 8'h00);
        check("service", irq_service, 16'h0001);
        @(posedge core_clk);
        irq_taken <= 1'h1;
        pc_target <= 16'h1234;
        @(posedge core_clk);
        irq_taken <= 1'h0;
        repeat (6) @(posedge core_clk);
        #1;
        check("ctx pcl", stack_mem[63], 16'h005A);
        check("ctx pch x", {stack_mem[62], stack_mem[61]}, 16'hA53C);
        check("ctx a fl", {stack_mem[60], stack_mem[59]}, 16'h81E5);
        check("sp five", stack_pointer, 16'h00FA);
        check("vector", program_counter, 16'h1234);
        check("mask on", condition_flags[3], 16'h0001);
        @(posedge core_clk);
        trap_request <= 1'h1;
        #1;
        check("trap", irq_service, 16'h0001);
        issue(cpu_register_set_pkg::OP_LOAD_A, 8'h00);
        issue(cpu_register_set_pkg::OP_INTERRUPT_RETURN, 8'h00);
        repeat (6) @(posedge core_clk);
        #1;
        check("ret flags", condition_flags, 16'h00E5);
        check("ret a x", {accumulator, index_first}, 16'h813C);
        check("ret y", index_second, 16'h00C3);
        check("ret pc", program_counter, 16'hA55A);
        check("ret sp", stack_pointer, 16'h00FF);
        $display("test irq done");
    endtask : test_irq
    initial begin
        resetn = 1'h0;
        op = cpu_register_set_pkg::OP_NONE;
        operand = 8'h00;
        logic_result = 8'h00;
        index_write = 1'h0;
        index_value = 8'h00;
        shift_carry = 1'h0;
        pc_target = 16'hA55A;
        irq_request = 8'h00;
        trap_request = 1'h0;
        irq_taken = 1'h0;
        n_mismatch = 0;
        checks = 0;
        for (int i = 0; i < 64; i++) begin
            stack_mem[i] = 8'h00;
        end
        repeat (5) @(posedge core_clk);
        resetn <= 1'h1;
        #1;
        test_reset();
        test_stack();
        test_alu();
        test_irq();
        complete_run();
    end
    initial begin
        #80000;
        n_mismatch++;
        complete_run();
    end
endmodule : cpu_register_set_tb
`default_nettype wire
